// ### hw/fsi_top.v
/*
 * fault status indication for a three-phase soft starter: tracks the
 * start state, latches faults, drives red alarm and green supply leds,
 * the alarm relay and the bypass relay, and times recovery.
 * assumes fault and status inputs are from pins (synchronised here) and
 * that a power cycle appears as sys_rst.
 */
`timescale 1ns/100ps
`include "fsi_consts.vh"

module fsi_top (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire       high_power,
    input  wire       large_unit,
    input  wire       start_req,
    input  wire       ramp_done,
    input  wire       line_phase_one,
    input  wire       line_phase_two,
    input  wire       line_phase_three,
    input  wire       phase_order_err,
    input  wire       volt_err,
    input  wire       freq_err,
    input  wire       overcurrent,
    input  wire       over_temp,
    input  wire       unbalance_err,
    input  wire       internal_err,
    output wire       led_red,
    output reg        led_green_q,
    output reg        alarm_relay_q,
    output reg        bypass_relay_q,
    output reg  [3:0] fault_class_q
);

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    localparam NIN = 14;
    wire [NIN-1:0] raw_in = {high_power, large_unit, start_req, ramp_done, line_phase_one, line_phase_two,
                             line_phase_three, phase_order_err, volt_err, freq_err, overcurrent,
                             over_temp, unbalance_err, internal_err};
    reg  [NIN-1:0] meta_q;
    reg  [NIN-1:0] sync_q;
    // two stages; only sync_q feeds logic
    always @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= {NIN{1'b0}};
            sync_q <= {NIN{1'b0}};
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end
    wire hp_s    = sync_q[13];
    wire large_s = sync_q[12];
    wire start_s = sync_q[11];
    wire rdone_s = sync_q[10];
    wire all_ph  = sync_q[9] & sync_q[8] & sync_q[7];
    wire no_ph   = ~(sync_q[9] | sync_q[8] | sync_q[7]);
    wire ord_s   = sync_q[6];
    wire volt_s  = sync_q[5];
    wire freq_s  = sync_q[4];
    wire oc_s    = sync_q[3];
    wire temp_s  = sync_q[2];
    wire unb_s   = sync_q[1];
    wire int_s   = sync_q[0];

    // ****************************************************************
    // millisecond tick divider
    // ****************************************************************
    // integer constants are cut to the counter width on purpose; the values fit
    localparam [31:0] TICK_LAST_W = `FSI_TICK_CYC - 1;
    localparam [14:0] TICK_LAST   = TICK_LAST_W[14:0];
    reg  [14:0] div_q;
    reg         tick_q;
    always @(posedge clk) begin
        if (sys_rst) begin
            div_q  <= 15'h0000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == TICK_LAST);
            div_q  <= (div_q == TICK_LAST) ? 15'h0000 : div_q + 15'h0001;
        end
    end

    // ****************************************************************
    // state machine
    // ****************************************************************
    localparam [2:0] ST_IDLE    = `FSI_ST_IDLE;
    localparam [2:0] ST_RAMP    = `FSI_ST_RAMP;
    localparam [2:0] ST_BYPASS  = `FSI_ST_BYPASS;
    localparam [2:0] ST_RECOVER = `FSI_ST_RECOVER;
    localparam [2:0] ST_ALARM   = `FSI_ST_ALARM;
    localparam [31:0] RECOVER_LAST_W = `FSI_RECOVER_MS - 1;
    localparam [31:0] RAMP_LAST_W    = `FSI_RAMP_MAX_MS - 1;
    localparam [18:0] RECOVER_LAST   = RECOVER_LAST_W[18:0];
    localparam [18:0] RAMP_LAST      = RAMP_LAST_W[18:0];

    reg  [2:0]  state_q;
    reg  [18:0] ms_q;        // ramp timer and recovery timer
    reg         to_prev_q;   // previous start ended in ramp timeout
    reg         latched_q;   // fault needs a power cycle
    reg         phase_gone_q;

    // ramp timeout has priority over ramp overcurrent since it names the stuck start
    wire        ramp_to = (state_q == ST_RAMP) && tick_q && (ms_q == RAMP_LAST) && !rdone_s;

    always @(posedge clk) begin
        if (sys_rst) begin
            state_q       <= ST_IDLE;
            ms_q          <= 19'h00000;
            to_prev_q     <= 1'b0;
            latched_q     <= 1'b0;
            phase_gone_q  <= 1'b0;
            fault_class_q <= `FSI_CLS_NONE;
        end else begin
            case (state_q)
            ST_IDLE, ST_RAMP, ST_BYPASS, ST_RECOVER: begin
                if (hp_s && int_s) begin
                    state_q       <= ST_ALARM;
                    fault_class_q <= `FSI_CLS_INTERNAL;
                    latched_q     <= 1'b1;
                    phase_gone_q  <= 1'b0;
                end else if (ord_s) begin
                    state_q       <= ST_ALARM;
                    fault_class_q <= `FSI_CLS_PHASE;
                end else if (volt_s || freq_s || temp_s || unb_s) begin
                    state_q       <= ST_ALARM;
                    ms_q          <= 19'h00000;
                    fault_class_q <= volt_s ? `FSI_CLS_VOLT : freq_s ? `FSI_CLS_FREQ :
                                     temp_s ? `FSI_CLS_TEMP : `FSI_CLS_UNBAL;
                end else if (ramp_to) begin
                    state_q       <= ST_ALARM;
                    ms_q          <= 19'h00000;
                    fault_class_q <= `FSI_CLS_RAMP_TO;
                    latched_q     <= hp_s && to_prev_q;
                    to_prev_q     <= 1'b1;
                end else if (oc_s && (state_q == ST_RAMP || state_q == ST_BYPASS)) begin
                    state_q       <= ST_ALARM;
                    ms_q          <= 19'h00000;
                    fault_class_q <= (state_q == ST_RAMP) ? `FSI_CLS_RAMP_OC : `FSI_CLS_BYP_OC;
                end else begin
                    case (state_q)
                    ST_IDLE: begin
                        if (start_s) begin
                            state_q <= ST_RAMP;
                            ms_q    <= 19'h00000;
                        end
                    end
                    ST_RAMP: begin
                        if (rdone_s) begin
                            state_q   <= ST_BYPASS;
                            to_prev_q <= 1'b0;
                        end else if (!start_s) begin
                            state_q <= ST_RECOVER;
                            ms_q    <= 19'h00000;
                        end else if (tick_q) begin
                            ms_q <= ms_q + 19'h00001;
                        end
                    end
                    ST_BYPASS: begin
                        if (!start_s) begin
                            state_q <= ST_RECOVER;
                            ms_q    <= 19'h00000;
                        end
                    end
                    default: begin
                        // recovery wait between starts
                        if (tick_q) begin
                            if (ms_q == RECOVER_LAST) begin
                                state_q <= ST_IDLE;
                                ms_q    <= 19'h00000;
                            end else begin
                                ms_q <= ms_q + 19'h00001;
                            end
                        end
                    end
                    endcase
                end
            end
            ST_ALARM: begin
                if (fault_class_q == `FSI_CLS_INTERNAL) begin
                    // clears only after all phases removed then all reapplied
                    if (no_ph) begin
                        phase_gone_q <= 1'b1;
                    end else if (phase_gone_q && all_ph) begin
                        state_q       <= ST_IDLE;
                        latched_q     <= 1'b0;
                        phase_gone_q  <= 1'b0;
                        fault_class_q <= `FSI_CLS_NONE;
                    end
                end else if (fault_class_q == `FSI_CLS_PHASE) begin
                    // a wiring change removes the cause; no timed recovery
                    if (!ord_s) begin
                        state_q       <= ST_IDLE;
                        fault_class_q <= `FSI_CLS_NONE;
                    end
                end else if (!latched_q && tick_q) begin
                    if (ms_q != RECOVER_LAST) begin
                        ms_q <= ms_q + 19'h00001;
                    end else if (fault_class_q != `FSI_CLS_UNBAL || all_ph) begin
                        state_q       <= ST_IDLE;
                        ms_q          <= 19'h00000;
                        fault_class_q <= `FSI_CLS_NONE;
                    end
                end
            end
            default: begin
                state_q <= ST_IDLE;
            end
            endcase
        end
    end

    // ****************************************************************
    // green led and relays
    // ****************************************************************
    localparam [31:0] GREEN_HALF_W = `FSI_GREEN_HALF_MS;
    localparam [18:0] GREEN_HALF   = GREEN_HALF_W[18:0];
    wire in_alarm = (state_q == ST_ALARM);
    // green blink phase taken from the recovery timer
    always @(posedge clk) begin
        if (sys_rst) begin
            led_green_q    <= 1'b0;
            alarm_relay_q  <= 1'b0;
            bypass_relay_q <= 1'b0;
        end else begin
            led_green_q    <= (state_q == ST_RECOVER) ? ((ms_q / GREEN_HALF) % 19'h00002 == 19'h00000)
                                                      : 1'b1;
            // 1 = fault pair (11/12 small, 11/14 large); small non-hp also while ramping
            alarm_relay_q  <= in_alarm || (!large_s && !hp_s && state_q == ST_RAMP);
            bypass_relay_q <= (state_q == ST_BYPASS);
        end
    end

    // red led is forced dark outside the alarm state
    wire [3:0] flash_count = in_alarm ? fault_class_q : `FSI_CLS_NONE;

    fsi_flasher u_flash (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick_ms (tick_q),
        .count   (flash_count),
        .led_q   (led_red)
    );

endmodule

// ### hw/fsi_consts.vh
/*
 * constants for the fault status indication block: fault class codes,
 * states, flash timing and recovery timing.
 * assumes a 20 MHz clock; included by the design files by bare name.
 */
`ifndef FSI_CONSTS_VH
`define FSI_CONSTS_VH

// ****************************************************************
// fault class codes (equal to the flash count, except 4'hf which shows steady on)
// ****************************************************************
`define FSI_CLS_NONE      4'h0
`define FSI_CLS_PHASE     4'h2
`define FSI_CLS_VOLT      4'h3
`define FSI_CLS_FREQ      4'h4
`define FSI_CLS_RAMP_OC   4'h5
`define FSI_CLS_RAMP_TO   4'h6
`define FSI_CLS_TEMP      4'h7
`define FSI_CLS_BYP_OC    4'h8
`define FSI_CLS_UNBAL     4'h9
`define FSI_CLS_INTERNAL  4'hf

// ****************************************************************
// top level states
// ****************************************************************
`define FSI_ST_IDLE       3'h0
`define FSI_ST_RAMP       3'h1
`define FSI_ST_BYPASS     3'h2
`define FSI_ST_RECOVER    3'h3
`define FSI_ST_ALARM      3'h4

// ****************************************************************
// timing
// ****************************************************************
`define FSI_CLK_HZ        20000000
`define FSI_TICK_MS       1
`define FSI_TICK_CYC      (`FSI_CLK_HZ / 1000 * `FSI_TICK_MS)
`define FSI_RAMP_MAX_MS   1000
`define FSI_RECOVER_MIN   5
`define FSI_RECOVER_MS    (`FSI_RECOVER_MIN * 60 * 1000)
`define FSI_FLASH_ON_MS   250
`define FSI_FLASH_OFF_MS  250
`define FSI_BURST_GAP_MS  1500
`define FSI_GREEN_HALF_MS 500

`endif

// ### hw/fsi_flasher.v
/*
 * flash count generator: repeats bursts of count flashes separated by a
 * long dark gap; count 4'hf means steady on, 0 means off.
 * assumes a one-cycle millisecond tick from the same clock.
 */
`timescale 1ns/100ps
`include "fsi_consts.vh"

module fsi_flasher (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire       tick_ms,
    input  wire [3:0] count,
    output reg        led_q
);

    reg  [10:0] ms_q;
    reg  [3:0]  done_q;
    reg         gap_q;

    // ****************************************************************
    // burst sequencer
    // ****************************************************************
    // a new count restarts the burst so the shown code is never mixed
    reg  [3:0]  cnt_last_q;
    always @(posedge clk) begin
        if (sys_rst) begin
            ms_q       <= 11'h000;
            done_q     <= 4'h0;
            gap_q      <= 1'b0;
            led_q      <= 1'b0;
            cnt_last_q <= 4'h0;
        end else begin
            cnt_last_q <= count;
            if (count != cnt_last_q || count == `FSI_CLS_NONE) begin
                ms_q   <= 11'h000;
                done_q <= 4'h0;
                gap_q  <= 1'b0;
                led_q  <= 1'b0;
            end else if (count == `FSI_CLS_INTERNAL) begin
                led_q <= 1'b1;
            end else if (tick_ms) begin
                ms_q <= ms_q + 11'h001;
                if (gap_q) begin
                    // long dark gap marks the burst boundary
                    if (ms_q == 11'd`FSI_BURST_GAP_MS - 11'h001) begin
                        gap_q  <= 1'b0;
                        ms_q   <= 11'h000;
                        done_q <= 4'h0;
                    end
                end else if (led_q) begin
                    if (ms_q == 11'd`FSI_FLASH_ON_MS - 11'h001) begin
                        led_q  <= 1'b0;
                        ms_q   <= 11'h000;
                        done_q <= done_q + 4'h1;
                    end
                end else if (done_q == count) begin
                    gap_q <= 1'b1;
                    ms_q  <= 11'h000;
                end else if (ms_q == 11'd`FSI_FLASH_OFF_MS - 11'h001 || done_q == 4'h0) begin
                    led_q <= 1'b1;
                    ms_q  <= 11'h000;
                end
            end
        end
    end

endmodule

// ### tb/fsi_checker.sv
/*
 * concurrent checks on the outputs of fsi_top.
 * assumes one clock clk and the synchronous active-high reset sys_rst.
 */
`timescale 1ns/100ps

module fsi_checker (
    input wire       clk,
    input wire       sys_rst,
    input wire       high_power,
    input wire       led_red,
    input wire       led_green_q,
    input wire       alarm_relay_q,
    input wire       bypass_relay_q,
    input wire [3:0] fault_class_q
);
    // ****************************************************************
    // output relations
    // ****************************************************************
    // one clock domain, so clocking and disable are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_reset_clears_out: assert property (disable iff (1'h0)
        sys_rst |=> fault_class_q == 4'h0 && !bypass_relay_q)
        else $error("outputs not cleared by reset");
    a_class_code_legal: assert property (fault_class_q inside {4'h0, [4'h2:4'h9], 4'hf})
        else $error("illegal fault class");
    // latched class may only change through zero, later faults are ignored
    a_class_held_alarm: assert property ($past(fault_class_q) != 4'h0 && fault_class_q != 4'h0
        |-> fault_class_q == $past(fault_class_q))
        else $error("fault class changed while alarmed");
    a_alarm_relay_set: assert property ((fault_class_q != 4'h0)[*2] |-> alarm_relay_q)
        else $error("alarm relay not on fault pair");
    a_bypass_open_alarm: assert property ((fault_class_q != 4'h0)[*2] |-> !bypass_relay_q)
        else $error("bypass relay closed while alarmed");
    a_green_on_alarm: assert property ((fault_class_q != 4'h0)[*2] |-> led_green_q)
        else $error("green led not steady in alarm");
    // three cycles allow for the flasher register behind the class
    a_red_dark_clear: assert property ((fault_class_q == 4'h0)[*3] |-> !led_red)
        else $error("red led lit outside alarm");
    a_internal_hp_only: assert property (fault_class_q == 4'hf |-> high_power)
        else $error("internal fault on standard unit");
endmodule

bind fsi_top fsi_checker i_fsi_checker (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .high_power     (high_power),
    .led_red        (led_red),
    .led_green_q    (led_green_q),
    .alarm_relay_q  (alarm_relay_q),
    .bypass_relay_q (bypass_relay_q),
    .fault_class_q  (fault_class_q)
);

// ### tb/fsi_panel_model.sv
/*
 * panel monitoring model: turns relay coils into the contact pair made.
 * assumes relay states are registered levels on the same clock.
 */
`timescale 1ns/100ps

module fsi_panel_model (
    input  wire       clk,
    input  wire       large_unit,
    input  wire       alarm_relay_q,
    input  wire       bypass_relay_q,
    output reg  [7:0] alarm_pair,
    output reg  [7:0] bypass_pair
);
    // ****************************************************************
    // contact sensing
    // ****************************************************************
    // fault pair is 11/12 on small units and 11/14 on large ones
    always @(posedge clk) begin
        alarm_pair  <= (alarm_relay_q ^ large_unit) ? 8'h12 : 8'h14;
        bypass_pair <= bypass_relay_q ? 8'h24 : 8'h22;
    end
endmodule

// ### tb/fsi_top_tb_top.sv
/*
 * self-checking bench for fsi_top with the panel model on the relays.
 * assumes 20 MHz clock; long recovery and ramp times are out of reach.
 */
`timescale 1ns/100ps

module fsi_top_tb_top;
    // ****************************************************************
    // stimulus and checking
    // ****************************************************************
    reg        clk, sys_rst, high_power, large_unit, start_req, ramp_done;
    reg  [2:0] ph;
    reg  [6:0] flt;
    wire       led_red, led_green_q, alarm_relay_q, bypass_relay_q;
    wire [3:0] fault_class_q;
    wire [7:0] alarm_pair, bypass_pair;
    integer    errors, n_checks, i;

    fsi_top i_dut (.clk(clk), .sys_rst(sys_rst), .high_power(high_power), .large_unit(large_unit),
        .start_req(start_req), .ramp_done(ramp_done), .line_phase_one(ph[0]), .line_phase_two(ph[1]),
        .line_phase_three(ph[2]), .phase_order_err(flt[6]), .volt_err(flt[5]), .freq_err(flt[4]),
        .over_temp(flt[3]), .unbalance_err(flt[2]), .internal_err(flt[1]), .overcurrent(flt[0]),
        .led_red(led_red), .led_green_q(led_green_q), .alarm_relay_q(alarm_relay_q),
        .bypass_relay_q(bypass_relay_q), .fault_class_q(fault_class_q));
    fsi_panel_model i_panel (.clk(clk), .large_unit(large_unit), .alarm_relay_q(alarm_relay_q),
        .bypass_relay_q(bypass_relay_q), .alarm_pair(alarm_pair), .bypass_pair(bypass_pair));

    // 50 ns period
    always #25 clk = ~clk;

    task check(input [7:0] seen, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task give_verdict;
        begin
            if (errors == 0 && n_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    // sample after the edge so the design's updates have landed
    task wait_cyc(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask

    task rst_dut(input hp, input lg);
        begin
            @(posedge clk);
            sys_rst <= 1'h1;
            high_power <= hp;
            large_unit <= lg;
            start_req <= 1'h0;
            ramp_done <= 1'h0;
            flt <= 7'h00;
            ph <= 3'h7;
            repeat (3) @(posedge clk);
            sys_rst <= 1'h0;
            wait_cyc(8); // straps pass the synchroniser first
        end
    endtask

    // first flash waits for the next millisecond tick, 20000 cycles
    task wait_red;
        integer k;
        begin
            // look 1 ns after each edge so the led has settled
            for (k = 0; k < 25000 && led_red !== 1'h1; k = k + 1)
                wait_cyc(1);
        end
    endtask

    task t_start_bypass;
        begin
            rst_dut(1'h0, 1'h0);
            check(fault_class_q, 8'h00);
            check(led_green_q, 8'h01);
            check(alarm_pair, 8'h14);
            @(posedge clk) start_req <= 1'h1;
            wait_cyc(8);
            check(alarm_pair, 8'h12);
            check(led_red, 8'h00);
            check(led_green_q, 8'h01);
            @(posedge clk) ramp_done <= 1'h1;
            wait_cyc(8);
            check(bypass_pair, 8'h24);
            check(alarm_pair, 8'h14);
            @(posedge clk) flt <= 7'h01;
            wait_cyc(8);
            check(fault_class_q, 8'h08);
            check(bypass_pair, 8'h22);
            check(alarm_pair, 8'h12);
        end
    endtask

    task t_ramp_overcurrent;
        begin
            rst_dut(1'h0, 1'h1);
            @(posedge clk) start_req <= 1'h1;
            wait_cyc(8);
            check(alarm_pair, 8'h12);
            @(posedge clk) flt <= 7'h01;
            wait_cyc(8);
            check(fault_class_q, 8'h05);
        end
    endtask

    // phase order, voltage, frequency, temperature, unbalance from idle
    task t_idle_faults;
        begin
            for (i = 0; i < 5; i = i + 1) begin
                rst_dut(1'h0, i[0]);
                @(posedge clk) flt <= 7'h40 >> i;
                wait_cyc(8);
                check(fault_class_q, (i < 3) ? i + 2 : (i == 3 ? 7 : 9));
                check(alarm_pair, i[0] ? 8'h14 : 8'h12);
            end
            wait_red;
            check(led_red, 8'h01);
        end
    endtask

    task t_internal;
        begin
            rst_dut(1'h1, 1'h0);
            // high-power small unit keeps the healthy pair while ramping
            @(posedge clk) start_req <= 1'h1;
            wait_cyc(8);
            check(alarm_pair, 8'h14);
            @(posedge clk) flt <= 7'h02;
            wait_cyc(8);
            check(fault_class_q, 8'h0f);
            wait_red;
            wait_cyc(2000);
            check(led_red, 8'h01);
            @(posedge clk) flt <= 7'h00;
            ph <= 3'h0;
            wait_cyc(8);
            check(fault_class_q, 8'h0f);
            @(posedge clk) ph <= 3'h7;
            wait_cyc(8);
            check(fault_class_q, 8'h00);
        end
    endtask

    initial begin
        clk = 1'h0;
        sys_rst = 1'h1;
        high_power = 1'h0;
        large_unit = 1'h0;
        start_req = 1'h0;
        ramp_done = 1'h0;
        ph = 3'h7;
        flt = 7'h00;
        errors = 0;
        n_checks = 0;
        t_start_bypass;
        t_ramp_overcurrent;
        t_idle_faults;
        t_internal;
        give_verdict;
    end

    // watchdog well past the two led waits
    initial begin
        #(80000 * 50);
        errors = errors + 1;
        give_verdict;
    end
endmodule
